//--- dma_chan_pkg.sv
// Register map, field layout and reset values of the DMA channel address block
package dma_chan_pkg;
    localparam int          ADDR_BITS         = 24;
    localparam logic [7:0]  OFF_ENABLE        = 8'h00;
    localparam logic [7:0]  OFF_MEM_CUR       = 8'h04;
    localparam logic [7:0]  OFF_MEM_LIMIT     = 8'h08;
    localparam logic [7:0]  OFF_MASTER_ADDR   = 8'h0c;
    localparam logic [7:0]  OFF_CONTROL       = 8'h10;
    localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h14;
    localparam logic [7:0]  OFF_IRQ_MASK      = 8'h18;
    localparam logic [7:0]  OFF_GLOBAL        = 8'h1c;
    localparam int          BIT_CHAN_ENABLE   = 0;
    localparam int          BIT_GLOBAL_ENABLE = 0;
    localparam int          BIT_MEM_INC       = 0;
    localparam int          BIT_MASTER_INC    = 1;
    localparam int          BIT_DONE          = 0;
    localparam int          SIZE_LSB          = 4;
    localparam int          SIZE_MSB          = 6;
    localparam logic [31:0] RESET_ADDR        = 32'h0000_0000;
    localparam logic [2:0]  RESET_SIZE        = 3'h1;
    localparam logic [31:0] IMPL_MASK         = 32'h00ff_ffff;

    typedef enum logic [1:0] {
        CH_IDLE   = 2'b00,
        CH_ACTIVE = 2'b01,
        CH_DONE   = 2'b11
    } chan_state_type;
endpackage

//--- dma_addr_step.sv
// Address advance unit: adds the packet size to an address when enabled
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step
    import dma_chan_pkg::*;
(
    input  wire logic [ADDR_BITS-1:0] addrIn,
    input  wire logic [2:0]           sizeIn,
    input  wire logic                 stepEn,
    output logic      [ADDR_BITS-1:0] addrOut
);
    always_comb begin
        if (stepEn) begin
            addrOut = ADDR_BITS'(addrIn + ADDR_BITS'(sizeIn));
        end else begin
            addrOut = addrIn;
        end
    end
endmodule
`default_nettype wire

//--- dma_channel_address_setup.sv
// DMA channel enable, memory/master address tracking, limit check and APB registers
// Behaviour
// - Channel enable bit 0 gates channel
// - Operate only with channel and global enable
// - Memory address advances by size per packet
// - Memory address drives the slave side
// - Current equals limit ends transfer, sets done
// - Limit applies only with memory increment on
// - Master address drives the flow-control master
// - Master address advances by size per packet
// - Address registers hold only bus-width bits
// - Global enable clear disables every channel
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_address_setup
    import dma_chan_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        packetDone,
    output logic             channelActive,
    output logic             transferDone,
    output logic      [31:0] slaveAddr,
    output logic      [31:0] masterAddr,
    output logic             irq
);
    logic                 chanEnable_q;
    logic                 globalEnable_q;
    logic                 memInc_q;
    logic                 masterInc_q;
    logic [2:0]           size_q;
    logic [ADDR_BITS-1:0] memCur_q;
    logic [ADDR_BITS-1:0] memLimit_q;
    logic [ADDR_BITS-1:0] master_q;
    logic [ADDR_BITS-1:0] memNext;
    logic [ADDR_BITS-1:0] masterNext;
    logic                 status_q;
    logic                 mask_q;
    logic                 pktSync1_q;
    logic                 pktSync2_q;
    logic                 pktSync3_q;
    logic                 pktLevel_q;
    logic                 pktEvent;
    logic                 run;
    logic                 limitHit;
    logic                 doneEvent;
    logic                 wrStb;
    logic                 rdStb;
    chan_state_type       state_q;
    chan_state_type       state_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, OFF_ENABLE) || hit(a, OFF_MEM_CUR) || hit(a, OFF_MEM_LIMIT)
              || hit(a, OFF_MASTER_ADDR) || hit(a, OFF_CONTROL)
              || hit(a, OFF_IRQ_STATUS) || hit(a, OFF_IRQ_MASK) || hit(a, OFF_GLOBAL);
    endfunction

    // Setup phase gives zero-wait access
    assign wrStb = psel && penable && pwrite && pready;
    assign rdStb = psel && !penable && !pwrite;

    // Packet-done from outside; a rise counts once stages two and three agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pktSync1_q <= 1'b0;
            pktSync2_q <= 1'b0;
            pktSync3_q <= 1'b0;
            pktLevel_q <= 1'b0;
        end else begin
            pktSync1_q <= packetDone;
            pktSync2_q <= pktSync1_q;
            pktSync3_q <= pktSync2_q;
            if (pktSync2_q == pktSync3_q) begin
                pktLevel_q <= pktSync3_q;
            end
        end
    end
    assign pktEvent = pktSync2_q && pktSync3_q && !pktLevel_q && (state_q == CH_ACTIVE);

    assign run      = chanEnable_q && globalEnable_q;
    assign limitHit = memInc_q && (memCur_q == memLimit_q);
    // Only a running channel finishes; a same-cycle disable wins over done
    assign doneEvent = (state_q == CH_ACTIVE) && run && limitHit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CH_IDLE: begin
                if (run) begin
                    state_d = CH_ACTIVE;
                end
            end
            CH_ACTIVE: begin
                if (!run) begin
                    state_d = CH_IDLE;
                end else if (limitHit) begin
                    state_d = CH_DONE;
                end
            end
            CH_DONE: begin
                if (!run) begin
                    state_d = CH_IDLE;
                end
            end
            default: state_d = CH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= CH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chanEnable_q   <= 1'b0;
            globalEnable_q <= 1'b0;
            memInc_q       <= 1'b0;
            masterInc_q    <= 1'b0;
            size_q         <= RESET_SIZE;
            mask_q         <= 1'b0;
        end else if (wrStb) begin
            if (hit(paddr, OFF_ENABLE)) begin
                chanEnable_q <= pwdata[BIT_CHAN_ENABLE];
            end
            if (hit(paddr, OFF_GLOBAL)) begin
                globalEnable_q <= pwdata[BIT_GLOBAL_ENABLE];
            end
            if (hit(paddr, OFF_CONTROL)) begin
                memInc_q    <= pwdata[BIT_MEM_INC];
                masterInc_q <= pwdata[BIT_MASTER_INC];
                size_q      <= pwdata[SIZE_MSB:SIZE_LSB];
            end
            if (hit(paddr, OFF_IRQ_MASK)) begin
                mask_q <= pwdata[BIT_DONE];
            end
        end
    end

    dma_addr_step u_memStep (
        .addrIn  (memCur_q),
        .sizeIn  (size_q),
        .stepEn  (pktEvent && memInc_q && !limitHit),
        .addrOut (memNext)
    );

    dma_addr_step u_masterStep (
        .addrIn  (master_q),
        .sizeIn  (size_q),
        .stepEn  (pktEvent && masterInc_q && !(memInc_q && limitHit)),
        .addrOut (masterNext)
    );

    // Firmware write wins over a hardware advance in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memCur_q   <= RESET_ADDR[ADDR_BITS-1:0];
            memLimit_q <= RESET_ADDR[ADDR_BITS-1:0];
            master_q   <= RESET_ADDR[ADDR_BITS-1:0];
        end else begin
            if (wrStb && hit(paddr, OFF_MEM_CUR)) begin
                memCur_q <= pwdata[ADDR_BITS-1:0];
            end else begin
                memCur_q <= memNext;
            end
            if (wrStb && hit(paddr, OFF_MEM_LIMIT)) begin
                memLimit_q <= pwdata[ADDR_BITS-1:0];
            end
            if (wrStb && hit(paddr, OFF_MASTER_ADDR)) begin
                master_q <= pwdata[ADDR_BITS-1:0];
            end else begin
                master_q <= masterNext;
            end
        end
    end

    // Done flag: set wins over write-one-to-clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 1'b0;
        end else if (doneEvent) begin
            status_q <= 1'b1;
        end else if (wrStb && hit(paddr, OFF_IRQ_STATUS) && pwdata[BIT_DONE]) begin
            status_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (rdStb) begin
                case (paddr)
                    OFF_ENABLE:      prdata <= {31'h0, chanEnable_q};
                    OFF_MEM_CUR:     prdata <= 32'(memCur_q);
                    OFF_MEM_LIMIT:   prdata <= 32'(memLimit_q);
                    OFF_MASTER_ADDR: prdata <= 32'(master_q);
                    OFF_CONTROL:     prdata <= {25'h0, size_q, 2'h0, masterInc_q, memInc_q};
                    OFF_IRQ_STATUS:  prdata <= {31'h0, status_q};
                    OFF_IRQ_MASK:    prdata <= {31'h0, mask_q};
                    OFF_GLOBAL:      prdata <= {31'h0, globalEnable_q};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channelActive <= 1'b0;
            transferDone  <= 1'b0;
            slaveAddr     <= RESET_ADDR;
            masterAddr    <= RESET_ADDR;
            irq           <= 1'b0;
        end else begin
            channelActive <= (state_d == CH_ACTIVE);
            transferDone  <= (state_d == CH_DONE);
            slaveAddr     <= 32'(memNext) & IMPL_MASK;
            masterAddr    <= 32'(masterNext) & IMPL_MASK;
            irq           <= (status_q || doneEvent) && mask_q;
        end
    end

    property p_gate;
        @(posedge clk) disable iff (!reset_n)
        !(chanEnable_q && globalEnable_q) |=> !channelActive;
    endproperty
    a_gate: assert property (p_gate) else $error("channel active while disabled");

    property p_global;
        @(posedge clk) disable iff (!reset_n)
        $fell(globalEnable_q) |-> ##[0:1] !channelActive;
    endproperty
    a_global: assert property (p_global) else $error("global clear left channel on");

    property p_memstep;
        @(posedge clk) disable iff (!reset_n)
        (pktEvent && memInc_q && !limitHit && !(wrStb && hit(paddr, OFF_MEM_CUR)))
            |=> memCur_q == ADDR_BITS'($past(memCur_q) + ADDR_BITS'($past(size_q)));
    endproperty
    a_memstep: assert property (p_memstep) else $error("memory address did not step");

    property p_mstep;
        @(posedge clk) disable iff (!reset_n)
        (pktEvent && masterInc_q && !limitHit && !(wrStb && hit(paddr, OFF_MASTER_ADDR)))
            |=> master_q == ADDR_BITS'($past(master_q) + ADDR_BITS'($past(size_q)));
    endproperty
    a_mstep: assert property (p_mstep) else $error("master address did not step");

    property p_done;
        @(posedge clk) disable iff (!reset_n)
        doneEvent |=> status_q && transferDone && !channelActive;
    endproperty
    a_done: assert property (p_done) else $error("limit hit without done");

    property p_nolimit;
        @(posedge clk) disable iff (!reset_n)
        !memInc_q && state_q == CH_ACTIVE && run |=> state_q == CH_ACTIVE;
    endproperty
    a_nolimit: assert property (p_nolimit) else $error("limit ended non-increment transfer");

    property p_width;
        @(posedge clk) disable iff (!reset_n)
        slaveAddr[31:ADDR_BITS] == 8'h00 && masterAddr[31:ADDR_BITS] == 8'h00;
    endproperty
    a_width: assert property (p_width) else $error("reserved address bits set");

    property p_readback;
        @(posedge clk) disable iff (!reset_n)
        rdStb && paddr == OFF_MEM_CUR |=> prdata == 32'($past(memCur_q));
    endproperty
    a_readback: assert property (p_readback) else $error("stale memory address read");

    property p_slave;
        @(posedge clk) disable iff (!reset_n)
        ##1 slaveAddr == 32'($past(memNext));
    endproperty
    a_slave: assert property (p_slave) else $error("slave address mismatch");

    property p_irq;
        @(posedge clk) disable iff (!reset_n)
        status_q && mask_q |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked done without interrupt");
endmodule
`default_nettype wire

//--- dma_master_model.sv
// Peripheral DMA master model: reports each completed packet by a pulse
`timescale 1ns/1ps
`default_nettype none
module dma_master_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic [3:0] numPackets,
    input  wire logic       slowMode,
    output logic            packetDone,
    output logic            busy
);
    logic [3:0] left_q;
    logic [3:0] phase_q;

    // High three cycles, then low three or more before the next packet
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= 4'h0;
            phase_q <= 4'h0;
        end else if (start && left_q == 4'h0) begin
            left_q <= numPackets;
            phase_q <= 4'h0;
        end else if (left_q != 4'h0) begin
            if (phase_q == (slowMode ? 4'h9 : 4'h5)) begin
                phase_q <= 4'h0;
                left_q <= left_q - 4'h1;
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end
    assign packetDone = (left_q != 4'h0) && (phase_q < 4'h3);
    assign busy = (left_q != 4'h0);
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the DMA channel address block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dma_chan_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } row_type;
    logic        clk, reset_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, slaveAddr, masterAddr, rd;
    logic        pready, pslverr, packetDone, channelActive, transferDone, irq;
    logic        start, slowMode, busy, er;
    logic [3:0]  numPackets;
    row_type     rows [6];
    int          errors, checks_done;

    dma_channel_address_setup dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .packetDone, .channelActive,
        .transferDone, .slaveAddr, .masterAddr, .irq);
    dma_master_model peer (.clk, .reset_n, .start, .numPackets, .slowMode,
        .packetDone, .busy);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic run(input logic [3:0] n, input logic slow);
        int k;
        @(posedge clk);
        numPackets <= n;
        slowMode <= slow;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (busy !== 1'b0 && k < 500);
        if (k >= 500) begin
            errors++;
        end
        repeat (6) @(posedge clk);
    endtask

    task automatic restart;
        wr(OFF_ENABLE, 32'h0);
        wr(OFF_ENABLE, 32'h1);
    endtask

    initial begin
        #80000;
        errors++;
        report_and_stop;
    end

    initial begin
        {reset_n, psel, penable, pwrite, start, slowMode} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        numPackets = 4'h0;
        errors = 0;
        checks_done = 0;
        rows = '{'{8'h04, 32'hffff_ffff, 32'h00ff_ffff}, '{8'h08, 32'hffab_cdef, 32'h00ab_cdef},
                 '{8'h0c, 32'h1234_5678, 32'h0034_5678}, '{8'h00, 32'h0000_0001, 32'h1},
                 '{8'h00, 32'h0, 32'h0}, '{8'h20, 32'hffff_ffff, 32'h0}};
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({29'h0, channelActive, transferDone, irq}, 32'h0);
        chk(slaveAddr, 32'h0);
        chk(masterAddr, 32'h0);
        for (int i = 0; i < 4; i++) rdc(8'(i * 4), 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk({31'h0, er}, 32'h1);
        $display("test registers ended");
        wr(OFF_MEM_CUR, 32'h100);
        wr(OFF_MEM_LIMIT, 32'h108);
        wr(OFF_MASTER_ADDR, 32'h2000);
        wr(OFF_CONTROL, 32'h43);
        wr(OFF_ENABLE, 32'h1);
        run(4'h2, 1'b0);
        chk({31'h0, channelActive}, 32'h0);
        chk(slaveAddr, 32'h100);
        wr(OFF_GLOBAL, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, channelActive}, 32'h1);
        run(4'h1, 1'b1);
        chk(slaveAddr, 32'h104);
        chk(masterAddr, 32'h2004);
        rdc(OFF_MEM_CUR, 32'h104);
        run(4'h1, 1'b0);
        chk({channelActive, transferDone, irq}, 32'h2);
        rdc(OFF_IRQ_STATUS, 32'h1);
        run(4'h1, 1'b0);
        chk(slaveAddr, 32'h108);
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("test transfer ended");
        restart;
        wr(OFF_GLOBAL, 32'h0);
        run(4'h1, 1'b0);
        chk({31'h0, channelActive}, 32'h0);
        chk(slaveAddr, 32'h108);
        wr(OFF_GLOBAL, 32'h1);
        wr(OFF_CONTROL, 32'h22);
        wr(OFF_MEM_CUR, 32'h300);
        wr(OFF_MEM_LIMIT, 32'h300);
        restart;
        run(4'h2, 1'b0);
        chk({30'h0, channelActive, transferDone}, 32'h2);
        chk(slaveAddr, 32'h300);
        chk(masterAddr, 32'h200c);
        wr(OFF_MEM_LIMIT, 32'h00ff_ffff);
        for (int s = 1; s <= 4; s *= 2) begin
            wr(OFF_CONTROL, 32'(s * 16 + 3));
            wr(OFF_MEM_CUR, 32'h0);
            restart;
            run(4'h1, 1'b0);
            chk(slaveAddr, 32'(s));
        end
        chk(masterAddr, 32'h2013);
        $display("test steps ended");
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({29'h0, channelActive, transferDone, irq}, 32'h0);
        chk(masterAddr, 32'h0);
        rdc(OFF_MEM_CUR, 32'h0);
        $display("test reset ended");
        report_and_stop;
    end
endmodule
`default_nettype wire
